// [bench/csd_link_host.sv]
/*
 * Two-wire host model that sends write-word frames to the decoder.
 * Assumes the bench resolves the data wire with a pull-up.
 */
module csd_link_host (
	// Link drive, high on the data line means released
	output logic       link_clk_out,
	output logic       sda_drv_out,
	// Resolved data wire and acknowledge summary
	input  wire logic  sda_in,
	output logic       ack_ok_out
);
	timeunit 1ns;
	timeprecision 10ps;

	// The link clock stands high between frames.
	initial begin
		link_clk_out = 1'b1;
		sda_drv_out = 1'b1;
		ack_ok_out = 1'b0;
	end

	// Index -1 is the acknowledge slot, where the host lets go of the line.
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= -1; i--) begin
			#31.25 sda_drv_out = (i < 0) ? 1'b1 : b[i];
			#31.25 link_clk_out = 1'b1;
			if (i < 0)
				ack_ok_out &= !sda_in;
			#62.5 link_clk_out = 1'b0;
		end
	endtask

	task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
			input logic [15:0] data, input int bytes);
		ack_ok_out = 1'b1;
		sda_drv_out = 1'b0;
		#62.5 link_clk_out = 1'b0;
		send_byte({addr, 1'b0});
		send_byte(cmd);
		send_byte(data[7:0]);
		if (bytes > 3)
			send_byte(data[15:8]);
		#31.25 sda_drv_out = 1'b0;
		#31.25 link_clk_out = 1'b1;
		#31.25 sda_drv_out = 1'b1;
		#250;
	endtask
endmodule

// [bench/csd_top_properties.sv]
/*
 * Concurrent checks on the outputs of the charger setpoint decoder.
 * Assumes it is bound to csd_top and sees only that module's ports.
 */
module csd_top_properties
	import csd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Observed inputs
	input  wire logic        adapter_supply_ok_in,
	input  wire logic        power_fail_in,
	input  wire logic        thermistor_sense_low_in,
	input  wire logic        battery_at_target_in,
	input  wire logic        input_over_limit_in,
	input  wire logic [10:0] voltage_ceiling_in,
	input  wire logic [5:0]  current_ceiling_in,
	// Observed outputs
	input  wire logic [10:0] voltage_dac_out,
	input  wire logic [5:0]  current_dac_out,
	input  wire logic [5:0]  input_dac_out,
	input  wire csd_loop_e   loop_select_out,
	input  wire logic        charge_enable_out,
	input  wire logic        load_switch_drive_out,
	input  wire logic        source_switch_drive_out,
	input  wire logic        adapter_present_flag_out,
	input  wire logic [15:0] status_out,
	input  wire logic [15:0] battery_voltage_target_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Sampled history still holds reset values just after release.
	logic [3:0] up_ff;
	logic [3:0] nxt_up;
	logic       settled;

	always_comb begin
		nxt_up = (up_ff == 4'h8) ? up_ff : up_ff + 4'h1;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			up_ff <= 4'h0;
		else
			up_ff <= nxt_up;
	end
	assign settled = (up_ff == 4'h8);

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_switch_inverse: assert property (
		load_switch_drive_out != source_switch_drive_out)
		else $error("load and source drives agree");
	a_source_select: assert property (
		(settled && $stable({adapter_supply_ok_in, power_fail_in}))[*6]
		|-> source_switch_drive_out
		== (adapter_supply_ok_in && !power_fail_in))
		else $error("source switch does not follow adapter state");
	a_adapter_status: assert property (
		(settled && $stable(adapter_supply_ok_in))[*6]
		|-> status_out[15] == adapter_supply_ok_in
		&& adapter_present_flag_out == adapter_supply_ok_in)
		else $error("adapter flag wrong");
	a_fail_status: assert property (
		(settled && $stable(power_fail_in))[*6]
		|-> status_out[13] == power_fail_in)
		else $error("power fail flag wrong");
	a_battery_status: assert property (
		(settled && $stable(thermistor_sense_low_in))[*6]
		|-> status_out[14] == thermistor_sense_low_in)
		else $error("battery flag wrong");
	a_loop_choice: assert property (
		(settled && $stable({input_over_limit_in, battery_at_target_in}))[*6]
		|-> loop_select_out == (input_over_limit_in ? CSD_LOOP_INPUT
		: battery_at_target_in ? CSD_LOOP_VOLTAGE : CSD_LOOP_CURRENT))
		else $error("wrong regulation loop");
	a_voltage_ceiling: assert property (
		(settled && $stable(voltage_ceiling_in))[*3]
		|-> voltage_dac_out <= voltage_ceiling_in)
		else $error("voltage code above ceiling");
	a_current_ceiling: assert property (
		(settled && $stable(current_ceiling_in))[*3]
		|-> current_dac_out <= current_ceiling_in)
		else $error("current code above ceiling");
	a_voltage_top: assert property (
		voltage_dac_out <= 11'h4b0)
		else $error("voltage code above saturation");
	a_input_floor: assert property (
		settled |-> input_dac_out >= 6'h02)
		else $error("input limit code below floor");
	a_charge_stop: assert property (
		(settled && $stable(battery_voltage_target_out))[*4]
		##0 (battery_voltage_target_out < 16'h0400) |-> !charge_enable_out)
		else $error("charging with a low voltage target");

	c_input_loop: cover property (loop_select_out == CSD_LOOP_INPUT);
	c_capped: cover property (current_dac_out == 6'h01
		&& current_ceiling_in > 6'h01);
	c_charging: cover property (charge_enable_out);
endmodule

bind csd_top csd_top_properties u_csd_top_properties (
	.clk_in(clk_in), .rst_n_in(rst_n_in),
	.adapter_supply_ok_in(adapter_supply_ok_in),
	.power_fail_in(power_fail_in),
	.thermistor_sense_low_in(thermistor_sense_low_in),
	.battery_at_target_in(battery_at_target_in),
	.input_over_limit_in(input_over_limit_in),
	.voltage_ceiling_in(voltage_ceiling_in),
	.current_ceiling_in(current_ceiling_in),
	.voltage_dac_out(voltage_dac_out), .current_dac_out(current_dac_out),
	.input_dac_out(input_dac_out), .loop_select_out(loop_select_out),
	.charge_enable_out(charge_enable_out),
	.load_switch_drive_out(load_switch_drive_out),
	.source_switch_drive_out(source_switch_drive_out),
	.adapter_present_flag_out(adapter_present_flag_out),
	.status_out(status_out),
	.battery_voltage_target_out(battery_voltage_target_out)
);

// [bench/csd_top_tb_top.sv]
/*
 * Self-checking bench of the charger setpoint decoder.
 * Assumes the host model and the bound checker are compiled first.
 */
`include "csd_cfg.svh"

module csd_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_in, rst_n_in, link_clk, sda_drv, ack_ok, sda_oe, sda_o;
	logic adapter_ok, power_fail, thm_low, battery_sense_low, battery_sense_ok;
	logic at_target, over_limit, chg_en, load_sw, src_sw, ac_flag, uv;
	logic [10:0] vdac, vceil;
	logic [5:0]  idac, indac, iceil;
	logic [1:0]  loop_sel;
	logic [15:0] status, vreg, ireg, inreg, v_req, i_req, in_req;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	logic [7:0]  cmds [3] = '{`CSD_CMD_VOLTAGE, `CSD_CMD_CURRENT,
		`CSD_CMD_INPUT};
	logic [15:0] corner [16] = '{16'h0000, 16'h0001, 16'h0080, 16'h0081,
		16'h03ff, 16'h0400, 16'h0100, 16'h0101, 16'h1f80, 16'h1f81,
		16'h2afc, 16'h2afd, 16'h4b00, 16'h4b01, 16'hffff, 16'h2000};
	wire         sda = sda_drv & ~(sda_oe & ~sda_o);

	csd_top u_csd_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link_clk_in(link_clk), .sda_in(sda), .sda_out(sda_o),
		.sda_oe_out(sda_oe), .adapter_supply_ok_in(adapter_ok),
		.power_fail_in(power_fail), .thermistor_sense_low_in(thm_low),
		.battery_sense_low_in(battery_sense_low), .battery_sense_ok_in(battery_sense_ok),
		.battery_at_target_in(at_target), .input_over_limit_in(over_limit),
		.voltage_ceiling_in(vceil), .current_ceiling_in(iceil),
		.voltage_dac_out(vdac), .current_dac_out(idac),
		.input_dac_out(indac), .loop_select_out(loop_sel),
		.charge_enable_out(chg_en), .load_switch_drive_out(load_sw),
		.source_switch_drive_out(src_sw),
		.adapter_present_flag_out(ac_flag), .status_out(status),
		.battery_voltage_target_out(vreg),
		.battery_current_target_out(ireg),
		.adapter_current_limit_out(inreg));

	csd_link_host u_csd_link_host (.link_clk_out(link_clk),
		.sda_drv_out(sda_drv), .sda_in(sda), .ack_ok_out(ack_ok));

	function automatic logic [10:0] v_code(input logic [15:0] d);
		if (d > 16'h4b00)
			d = 16'h4b00;
		if (d < 16'h0400)
			d = 16'h0000;
		return d[14:4];
	endfunction

	function automatic logic [5:0] i_code(input logic [15:0] d);
		if (d != 16'h0000 && d < 16'h0080)
			d = 16'h0080;
		if (d > 16'h1f80)
			d = 16'h1f80;
		return d[12:7];
	endfunction

	// Clipped input limits too wide for six bits pin the code at full scale.
	function automatic logic [5:0] in_code(input logic [15:0] d);
		if (d < 16'h0100)
			d = 16'h0100;
		if (d > 16'h2afc)
			d = 16'h2afc;
		return d[13] ? 6'h3f : d[12:7];
	endfunction

	task automatic results();
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic verify();
		logic [10:0] ve;
		logic [10:0] vx;
		logic [5:0]  ie;
		logic        src;
		logic        chg;
		logic [1:0]  lp;
		logic [2:0]  sw;
		ve = v_code(v_req);
		ie = (i_code(i_req) < iceil) ? i_code(i_req) : iceil;
		if (uv && ie > 6'h01)
			ie = 6'h01;
		src = adapter_ok & !power_fail;
		vx = (ve < vceil) ? ve : vceil;
		chg = src && (vx != 11'h000) && (ie != 6'h00);
		lp = over_limit ? 2'h2 : at_target ? 2'h1 : 2'h0;
		sw = {src, !src, adapter_ok};
		repeat (8) @(negedge clk_in);
		check(16'(vdac), 16'(vx));
		check(16'(idac), 16'(ie));
		check(16'(indac), 16'(in_code(in_req)));
		check(status, {adapter_ok, thm_low, power_fail, 13'h0});
		check(16'({src_sw, load_sw, ac_flag}), 16'(sw));
		check(16'(loop_sel), 16'(lp));
		check(16'(chg_en), 16'(chg));
		check(vreg, v_req);
		check(ireg, i_req);
		check(inreg, in_req);
		if (ve == 11'h000)
			check(16'(chg_en), 16'h0000);
	endtask

	task automatic send(input logic [6:0] addr, input logic [7:0] cmd,
			input logic [15:0] data, input int bytes);
		u_csd_link_host.write_word(addr, cmd, data, bytes);
		check(16'(ack_ok), 16'(addr == `CSD_BUS_ADDR));
		if (addr == `CSD_BUS_ADDR && bytes == 4) begin
			if (cmd == `CSD_CMD_VOLTAGE)
				v_req = data;
			if (cmd == `CSD_CMD_CURRENT)
				i_req = data;
			if (cmd == `CSD_CMD_INPUT)
				in_req = data;
		end
		verify();
	endtask

	task automatic do_reset();
		rst_n_in = 1'b0;
		{v_req, i_req, in_req, uv} = {16'h0000, 16'h0080, 16'h0100, 1'b0};
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		verify();
		check(vreg, 16'h0000);
		check(ireg, 16'h0080);
		check(inreg, 16'h0100);
	endtask

	task automatic stir();
		@(negedge clk_in);
		{adapter_ok, power_fail, thm_low, at_target, over_limit} = 5'($urandom());
		vceil = ($urandom() % 4 == 0) ? 11'($urandom()) : 11'h7ff;
		iceil = ($urandom() % 4 == 0) ? 6'($urandom()) : 6'h3f;
	endtask

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// A full run needs about 35000 cycles.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 80000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		void'($urandom(55));
		{adapter_ok, power_fail, thm_low, battery_sense_low, battery_sense_ok} = 5'b10001;
		{at_target, over_limit, vceil, iceil} = {2'b00, 11'h7ff, 6'h3f};
		do_reset();
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 16; k++) begin
				stir();
				send(`CSD_BUS_ADDR, cmds[c], corner[k], 4);
			end
		end
		repeat (12) begin
			stir();
			send(`CSD_BUS_ADDR, cmds[$urandom() % 3], 16'($urandom()), 4);
		end
		send(7'h0a, `CSD_CMD_VOLTAGE, 16'h3000, 4);
		send(`CSD_BUS_ADDR, `CSD_CMD_CURRENT, 16'h0000, 3);
		send(`CSD_BUS_ADDR, 8'h16, 16'h0000, 4);
		// Conditioning: charging off, system on battery, then recharge.
		{adapter_ok, power_fail} = 2'b00;
		send(`CSD_BUS_ADDR, `CSD_CMD_CURRENT, 16'h0000, 4);
		adapter_ok = 1'b1;
		send(`CSD_BUS_ADDR, `CSD_CMD_CURRENT, 16'h1000, 4);
		iceil = 6'h3f;
		send(`CSD_BUS_ADDR, `CSD_CMD_CURRENT, 16'h1000, 4);
		{battery_sense_low, battery_sense_ok, uv} = 3'b101;
		verify();
		battery_sense_low = 1'b0;
		verify();
		{battery_sense_ok, uv} = 2'b10;
		verify();
		check(ireg, 16'h1000);
		do_reset();
		results();
	end
endmodule

// [logic/csd_cfg.svh]
/*
 * Constants of the charger setpoint decoder: link address, command codes,
 * request thresholds, DAC codes, reset values and status bit positions.
 * Assumes it is included by bare name from the design files and the bench.
 */
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// Link address (7 bits) and write-word command codes.
`define CSD_BUS_ADDR        7'h09
`define CSD_CMD_VOLTAGE     8'h15
`define CSD_CMD_CURRENT     8'h14
`define CSD_CMD_INPUT       8'h3f

// Bit counter slots of one write-word frame.
`define CSD_SLOT_ADDR_LAST  6'h07
`define CSD_SLOT_CMD_LAST   6'h10
`define CSD_SLOT_LOW_LAST   6'h19
`define CSD_SLOT_HIGH_LAST  6'h22
`define CSD_SLOT_ACK0       6'h08
`define CSD_SLOT_ACK1       6'h11
`define CSD_SLOT_ACK2       6'h1a
`define CSD_SLOT_ACK3       6'h23

// Charge voltage, millivolts per step.
`define CSD_V_LSB_DROP      4
`define CSD_V_SAT_MV        16'h4b00
`define CSD_V_MIN_MV        16'h0400
// Charge current, milliamps per step.
`define CSD_I_LSB_DROP      7
`define CSD_I_SAT_MA        16'h1f80
`define CSD_I_MIN_MA        16'h0080
`define CSD_I_UV_CODE       6'h01
// Adapter input current limit, milliamps per step.
`define CSD_IN_SAT_MA       16'h2afc
`define CSD_IN_MIN_MA       16'h0100

// Reset values of the three setpoint registers.
`define CSD_RST_VOLTAGE     16'h0000
`define CSD_RST_CURRENT     16'h0080
`define CSD_RST_INPUT       16'h0100

// Status word bit positions.
`define CSD_ST_ADAPTER      15
`define CSD_ST_BATTERY      14
`define CSD_ST_POWER_FAIL   13

`endif

// [logic/csd_link_rx.sv]
/*
 * Write-word receiver clocked by the link clock. Shifts address, command
 * and two data bytes, acknowledges its own address and hands a finished
 * word over by a toggle. Assumes frame_rst_n_in is held low between frames
 * by the system-clock side and released after a start condition.
 */
`include "csd_cfg.svh"

module csd_link_rx (
	// Link clock and resets
	input  wire logic        link_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        frame_rst_n_in,
	// Link data
	input  wire logic        sda_in,
	output logic             sda_oe_out,
	// Word hand-over
	output logic             word_toggle_out,
	output logic [7:0]       cmd_out,
	output logic [15:0]      data_out
);

	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic       match_ff;
	logic       nxt_match;
	logic [7:0] cmd_ff;
	logic [7:0] nxt_cmd;
	logic [7:0] low_ff;
	logic [7:0] nxt_low;
	logic       tog_ff;
	logic       nxt_tog;
	logic [15:0] data_ff;
	logic [15:0] nxt_data;
	logic [7:0] cmd_hold_ff;
	logic [7:0] nxt_cmd_hold;
	logic       oe_ff;
	logic       nxt_oe;
	logic [7:0] byte_in;
	logic       ack_slot;

	assign byte_in = {shift_ff[6:0], sda_in};

	always_comb begin
		nxt_cnt      = cnt_ff;
		nxt_shift    = shift_ff;
		nxt_match    = match_ff;
		nxt_cmd      = cmd_ff;
		nxt_low      = low_ff;
		nxt_tog      = tog_ff;
		nxt_data     = data_ff;
		nxt_cmd_hold = cmd_hold_ff;
		if (cnt_ff <= `CSD_SLOT_ACK3) begin
			nxt_cnt = cnt_ff + 6'h01;
		end
		nxt_shift = byte_in;
		case (cnt_ff)
			`CSD_SLOT_ADDR_LAST: begin
				// Reads are not served, so a read address is not ours.
				nxt_match = (byte_in[7:1] == `CSD_BUS_ADDR) && !byte_in[0];
			end
			`CSD_SLOT_CMD_LAST: begin
				nxt_cmd = byte_in;
			end
			`CSD_SLOT_LOW_LAST: begin
				nxt_low = byte_in;
			end
			`CSD_SLOT_HIGH_LAST: begin
				if (match_ff) begin
					nxt_data     = {byte_in, low_ff};
					nxt_cmd_hold = cmd_ff;
					nxt_tog      = !tog_ff;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge link_clk_in or negedge frame_rst_n_in) begin
		if (!frame_rst_n_in) begin
			cnt_ff   <= 6'h00;
			shift_ff <= 8'h00;
			match_ff <= 1'b0;
			cmd_ff   <= 8'h00;
			low_ff   <= 8'h00;
		end else begin
			cnt_ff   <= nxt_cnt;
			shift_ff <= nxt_shift;
			match_ff <= nxt_match;
			cmd_ff   <= nxt_cmd;
			low_ff   <= nxt_low;
		end
	end

	// The hand-over survives the end of a frame so the far side can copy it.
	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tog_ff      <= 1'b0;
			data_ff     <= 16'h0000;
			cmd_hold_ff <= 8'h00;
		end else begin
			tog_ff      <= nxt_tog;
			data_ff     <= nxt_data;
			cmd_hold_ff <= nxt_cmd_hold;
		end
	end

	// Acknowledge is driven from a falling edge to the next one.
	assign ack_slot = (cnt_ff == `CSD_SLOT_ACK0) ||
	                  (cnt_ff == `CSD_SLOT_ACK1) ||
	                  (cnt_ff == `CSD_SLOT_ACK2) ||
	                  (cnt_ff == `CSD_SLOT_ACK3);

	always_comb begin
		nxt_oe = match_ff && ack_slot;
	end

	always_ff @(negedge link_clk_in or negedge frame_rst_n_in) begin
		if (!frame_rst_n_in) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= nxt_oe;
		end
	end

	assign sda_oe_out      = oe_ff;
	assign word_toggle_out = tog_ff;
	assign cmd_out         = cmd_hold_ff;
	assign data_out        = data_ff;

endmodule

// [logic/csd_pkg.sv]
/*
 * Types shared by the charger setpoint decoder.
 * Assumes nothing of its surroundings.
 */
package csd_pkg;

	typedef enum logic [1:0] {
		CSD_LOOP_CURRENT = 2'b00,
		CSD_LOOP_VOLTAGE = 2'b01,
		CSD_LOOP_INPUT   = 2'b10
	} csd_loop_e;

endpackage

// [logic/csd_top.sv]
/*
 * Charger setpoint decoder: receives setpoint words over the two-wire link,
 * turns them into DAC codes with truncation, saturation, minimum and
 * ceilings, selects the regulating loop and drives the power switches.
 * Assumes analog comparator results arrive asynchronously as levels, and
 * ceiling codes arrive already scaled and stable on the system clock.
 */
// Function
// - Voltage word in mV; drop four LSBs, eleven bits drive voltage DAC.
// - Voltage requests above 19.200 V saturate to the 19.200 V code.
// - Voltage requests below 1.024 V give zero target and stop charging.
// - Voltage ceiling replaces the programmed target when it is lower.
// - Current word in mA; drop seven LSBs, six bits drive current DAC.
// - Current requests above 8.064 A saturate to the 8.064 A code.
// - Nonzero current requests up to 128 mA are raised to 128 mA.
// - Current setting resets to 128 mA until a new write.
// - Current ceiling replaces the programmed current when it is lower.
// - Input limit word; drop seven LSBs, six bits drive input DAC.
// - Input limit requests above 11.004 A clip there, which pins the input DAC code at 0x3f.
// - Input limit requests up to 256 mA are raised to 256 mA.
// - Input limit resets to 256 mA until a new write.
// - Current loop rules below voltage target; voltage loop at target.
// - Input-limit loop takes over when total input exceeds the limit.
// - Adapter presence chooses the source via load and source switches.
// - Adapter above 7.5 V means present, charging allowed, status bit 15.
// - Adapter below battery plus 0.3 V opens source switch, status bit 13.
// - Thermistor below 91 percent of supply flags battery present, bit 14.
// - Battery undervoltage caps current at 128 mA until above 2.7 V.
`include "csd_cfg.svh"

module csd_top
	import csd_pkg::*;
(
	// System clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Two-wire link
	input  wire logic        link_clk_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// Analog comparator results
	input  wire logic        adapter_supply_ok_in,
	input  wire logic        power_fail_in,
	input  wire logic        thermistor_sense_low_in,
	input  wire logic        battery_sense_low_in,
	input  wire logic        battery_sense_ok_in,
	input  wire logic        battery_at_target_in,
	input  wire logic        input_over_limit_in,
	// Ceiling codes
	input  wire logic [10:0] voltage_ceiling_in,
	input  wire logic [5:0]  current_ceiling_in,
	// DAC codes
	output logic [10:0]      voltage_dac_out,
	output logic [5:0]       current_dac_out,
	output logic [5:0]       input_dac_out,
	// Loop and switch control
	output csd_loop_e        loop_select_out,
	output logic             charge_enable_out,
	output logic             load_switch_drive_out,
	output logic             source_switch_drive_out,
	// Status
	output logic             adapter_present_flag_out,
	output logic [15:0]      status_out,
	output logic [15:0]      battery_voltage_target_out,
	output logic [15:0]      battery_current_target_out,
	output logic [15:0]      adapter_current_limit_out
);

	localparam int NSYNC = 9;

	// Two-stage synchronisers for every asynchronous level.
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;

	assign raw_in = {input_over_limit_in, battery_at_target_in,
	                 battery_sense_ok_in, battery_sense_low_in,
	                 thermistor_sense_low_in, power_fail_in,
	                 adapter_supply_ok_in, sda_in, link_clk_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				// Link wires idle high; a low reset value would fake a start.
				if (!rst_n_in) begin
					sync1_ff[gi] <= (gi < 2) ? 1'b1 : 1'b0;
					sync2_ff[gi] <= (gi < 2) ? 1'b1 : 1'b0;
				end else begin
					sync1_ff[gi] <= raw_in[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic adapter_ok_s;
	logic pfail_s;
	logic thm_low_s;
	logic battery_sense_low_s;
	logic battery_sense_ok_s;
	logic at_target_s;
	logic over_limit_s;

	assign {over_limit_s, at_target_s, battery_sense_ok_s, battery_sense_low_s, thm_low_s,
	        pfail_s, adapter_ok_s, sda_s, scl_s} = sync2_ff;

	// Start and stop detection frames the link-side receiver.
	logic sda_prev_ff;
	logic nxt_sda_prev;
	logic idle_ff;
	logic nxt_idle;

	always_comb begin
		nxt_sda_prev = sda_s;
		nxt_idle     = idle_ff;
		if (scl_s && sda_prev_ff && !sda_s) begin
			nxt_idle = 1'b0;
		end else if (scl_s && !sda_prev_ff && sda_s) begin
			nxt_idle = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sda_prev_ff <= 1'b1;
			idle_ff     <= 1'b1;
		end else begin
			sda_prev_ff <= nxt_sda_prev;
			idle_ff     <= nxt_idle;
		end
	end

	// The receiver is held in reset while the link is idle; release comes
	// a few system clocks after a start, well before the first bit edge.
	logic        frame_rst_n;
	logic        word_toggle;
	logic [7:0]  rx_cmd;
	logic [15:0] rx_data;

	assign frame_rst_n = rst_n_in && !idle_ff;

	csd_link_rx u_rx (
		.link_clk_in     (link_clk_in),
		.rst_n_in        (rst_n_in),
		.frame_rst_n_in  (frame_rst_n),
		.sda_in          (sda_in),
		.sda_oe_out      (sda_oe_out),
		.word_toggle_out (word_toggle),
		.cmd_out         (rx_cmd),
		.data_out        (rx_data)
	);

	assign sda_out = 1'b0;

	// Word hand-over: the toggle crosses, the word is stable meanwhile.
	logic tog1_ff;
	logic tog2_ff;
	logic tog3_ff;
	logic word_stb;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tog1_ff <= 1'b0;
			tog2_ff <= 1'b0;
			tog3_ff <= 1'b0;
		end else begin
			tog1_ff <= word_toggle;
			tog2_ff <= tog1_ff;
			tog3_ff <= tog2_ff;
		end
	end

	assign word_stb = tog2_ff ^ tog3_ff;

	// Setpoint registers.
	logic [15:0] volt_ff;
	logic [15:0] nxt_volt;
	logic [15:0] curr_ff;
	logic [15:0] nxt_curr;
	logic [15:0] inlim_ff;
	logic [15:0] nxt_inlim;

	always_comb begin
		nxt_volt  = volt_ff;
		nxt_curr  = curr_ff;
		nxt_inlim = inlim_ff;
		if (word_stb) begin
			case (rx_cmd)
				`CSD_CMD_VOLTAGE: nxt_volt  = rx_data;
				`CSD_CMD_CURRENT: nxt_curr  = rx_data;
				`CSD_CMD_INPUT:   nxt_inlim = rx_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			volt_ff  <= `CSD_RST_VOLTAGE;
			curr_ff  <= `CSD_RST_CURRENT;
			inlim_ff <= `CSD_RST_INPUT;
		end else begin
			volt_ff  <= nxt_volt;
			curr_ff  <= nxt_curr;
			inlim_ff <= nxt_inlim;
		end
	end

	// Request decoding.
	logic [15:0] volt_clip;
	logic [10:0] volt_code;
	logic [15:0] curr_clip;
	logic [5:0]  curr_code;
	logic [15:0] inlim_clip;
	logic [5:0]  inlim_code;

	always_comb begin
		volt_clip = volt_ff;
		if (volt_ff > `CSD_V_SAT_MV) begin
			volt_clip = `CSD_V_SAT_MV;
		end else if (volt_ff < `CSD_V_MIN_MV) begin
			volt_clip = 16'h0000;
		end
		volt_code = volt_clip[`CSD_V_LSB_DROP +: 11];
	end

	always_comb begin
		curr_clip = curr_ff;
		if (curr_ff == 16'h0000) begin
			curr_clip = 16'h0000;
		end else if (curr_ff <= `CSD_I_MIN_MA) begin
			curr_clip = `CSD_I_MIN_MA;
		end else if (curr_ff > `CSD_I_SAT_MA) begin
			curr_clip = `CSD_I_SAT_MA;
		end
		curr_code = curr_clip[`CSD_I_LSB_DROP +: 6];
	end

	// Limit requests whose code would pass six bits hold the top code.
	always_comb begin
		inlim_clip = inlim_ff;
		if (inlim_ff <= `CSD_IN_MIN_MA) begin
			inlim_clip = `CSD_IN_MIN_MA;
		end else if (inlim_ff > `CSD_IN_SAT_MA) begin
			inlim_clip = `CSD_IN_SAT_MA;
		end
		if (inlim_clip[15:13] != 3'h0) begin
			inlim_code = 6'h3f;
		end else begin
			inlim_code = inlim_clip[`CSD_I_LSB_DROP +: 6];
		end
	end

	// Battery undervoltage with hysteresis between the two thresholds.
	logic uv_ff;
	logic nxt_uv;

	always_comb begin
		nxt_uv = uv_ff;
		if (battery_sense_low_s) begin
			nxt_uv = 1'b1;
		end else if (battery_sense_ok_s) begin
			nxt_uv = 1'b0;
		end
	end

	// Ceilings, cap, loop choice and switches.
	logic        v_over;
	logic        i_over;
	logic [10:0] volt_eff;
	logic [5:0]  curr_lim;
	logic [5:0]  curr_eff;
	logic        present;
	logic        source_on;
	logic        chg_en;
	csd_loop_e   nxt_loop;

	assign v_over   = volt_code > voltage_ceiling_in;
	assign i_over   = curr_code > current_ceiling_in;
	assign volt_eff = v_over ? voltage_ceiling_in : volt_code;
	assign curr_lim = i_over ? current_ceiling_in : curr_code;
	assign present  = adapter_ok_s;
	assign source_on = present && !pfail_s;

	always_comb begin
		curr_eff = curr_lim;
		// The stored setting is untouched; only compliance is reduced.
		if (uv_ff && (curr_lim > `CSD_I_UV_CODE)) begin
			curr_eff = `CSD_I_UV_CODE;
		end
		chg_en = source_on && (volt_eff != 11'h000) &&
		         (curr_eff != 6'h00);
		case ({over_limit_s, at_target_s})
			2'b00:   nxt_loop = CSD_LOOP_CURRENT;
			2'b01:   nxt_loop = CSD_LOOP_VOLTAGE;
			2'b10:   nxt_loop = CSD_LOOP_INPUT;
			2'b11:   nxt_loop = CSD_LOOP_INPUT;
			default: nxt_loop = CSD_LOOP_CURRENT;
		endcase
	end

	logic [10:0] vdac_ff;
	logic [5:0]  idac_ff;
	logic [5:0]  indac_ff;
	csd_loop_e   loop_ff;
	logic        chg_ff;
	logic        src_ff;
	logic        pres_ff;
	logic [15:0] status_ff;
	logic [15:0] nxt_status;

	always_comb begin
		nxt_status = 16'h0000;
		nxt_status[`CSD_ST_ADAPTER]    = present;
		nxt_status[`CSD_ST_BATTERY]    = thm_low_s;
		nxt_status[`CSD_ST_POWER_FAIL] = pfail_s;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			uv_ff     <= 1'b0;
			vdac_ff   <= 11'h000;
			idac_ff   <= 6'h00;
			indac_ff  <= 6'h00;
			loop_ff   <= CSD_LOOP_CURRENT;
			chg_ff    <= 1'b0;
			src_ff    <= 1'b0;
			pres_ff   <= 1'b0;
			status_ff <= 16'h0000;
		end else begin
			uv_ff     <= nxt_uv;
			vdac_ff   <= volt_eff;
			idac_ff   <= curr_eff;
			indac_ff  <= inlim_code;
			loop_ff   <= nxt_loop;
			chg_ff    <= chg_en;
			src_ff    <= source_on;
			pres_ff   <= present;
			status_ff <= nxt_status;
		end
	end

	assign voltage_dac_out            = vdac_ff;
	assign current_dac_out            = idac_ff;
	assign input_dac_out              = indac_ff;
	assign loop_select_out            = loop_ff;
	assign charge_enable_out          = chg_ff;
	assign source_switch_drive_out    = src_ff;
	assign load_switch_drive_out      = !src_ff;
	assign adapter_present_flag_out   = pres_ff;
	assign status_out                 = status_ff;
	assign battery_voltage_target_out = volt_ff;
	assign battery_current_target_out = curr_ff;
	assign adapter_current_limit_out  = inlim_ff;

endmodule
